/* rtl/pwr_seq_cfg.svh */
// timing constants and pin defaults for the power-on sequencer
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH
`define CLK_FREQ_HZ 100000000
`define KEY_HOLD_MS 1000
`define KEY_HOLD_CYC ((`CLK_FREQ_HZ / 1000) * `KEY_HOLD_MS)
`define OPER_DELAY_MS 20000
`define OPER_DELAY_CYC ((`CLK_FREQ_HZ / 1000) * `OPER_DELAY_MS)
`define PAD_CFG_MS 10
`define PAD_CFG_CYC ((`CLK_FREQ_HZ / 1000) * `PAD_CFG_MS)
`define OFF_KEY_HOLD_MS 2500
`define OFF_KEY_HOLD_CYC ((`CLK_FREQ_HZ / 1000) * `OFF_KEY_HOLD_MS)
`define FINAL_MS 15000
`define FINAL_CYC ((`CLK_FREQ_HZ / 1000) * `FINAL_MS)
`define GPIO8_SW_READY_DEFAULT 1'b1
`define CNT_W 32
`endif

/* rtl/pwr_seq_pkg.sv */
// types for the power-on sequencer
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_PAD_INIT,
        ST_SW_INIT,
        ST_ACTIVE,
        ST_FINAL
    } seq_state_t;
endpackage

/* rtl/key_filter.sv */
// synchroniser and low-pulse length measurement for the power key pad
`timescale 1ns/10ps
module key_filter (
    input wire logic mclk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic key_n_in, // raw power key pad level
    input wire logic [31:0] hold_on_cyc, // hold for power-on
    input wire logic [31:0] hold_off_cyc, // hold for power-off
    output logic on_pulse, // one cycle: valid on pulse released
    output logic off_pulse // one cycle: valid off pulse released
);
    logic s1_q;
    logic s2_q;
    logic [31:0] cnt_q;

    // two flops before any logic; s1 read only by s2
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            s1_q <= key_n_in;
            s2_q <= s1_q;
        end
    end

    // low time counted; judged on release so the host must let go
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h0;
            on_pulse <= 1'b0;
            off_pulse <= 1'b0;
        end else begin
            on_pulse <= s2_q && (cnt_q >= hold_on_cyc);
            off_pulse <= s2_q && (cnt_q >= hold_off_cyc);
            if (s2_q)
                cnt_q <= 32'h0;
            else if (cnt_q != 32'hffffffff)
                cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule // key_filter

/* rtl/module_power_on_sequencer.sv */
// device-side power-on sequencer: power key in, status lines out
// Overview of operation
// - after valid pulse run init sequence; module inaccessible until done
// - module never operational earlier than twenty seconds after key assertion
// - software-ready appears on general-purpose pin eight by default
// - software-ready goes high only when fully on and accepting commands
// - power-monitor rises only after every pad is configured
// - power-monitor goes low once the module is fully powered off
// - names ending in hash or _n are active low for both sides
`timescale 1ns/10ps
`include "pwr_seq_cfg.svh"
module module_power_on_sequencer #(
    parameter logic [31:0] KEY_HOLD_CYC = 32'(`KEY_HOLD_CYC),
    parameter logic [31:0] OPER_DELAY_CYC = 32'(`OPER_DELAY_CYC),
    parameter logic [31:0] PAD_CFG_CYC = 32'(`PAD_CFG_CYC),
    parameter logic [31:0] OFF_KEY_HOLD_CYC = 32'(`OFF_KEY_HOLD_CYC),
    parameter logic [31:0] FINAL_CYC = 32'(`FINAL_CYC)
) (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic nrst, // async reset, active low
    input wire logic power_key_n_in, // power key pad level
    output logic power_key_n_out, // pad drive value, always low when driven
    output logic power_key_n_oe, // pad drive enable, never set
    input wire logic gpio8_alt_sel, // reconfigures pin eight away from ready
    input wire logic gpio8_alt_val, // pin eight value when reconfigured
    output logic gpio8_out, // general-purpose pin eight
    output logic software_ready, // high once commands are accepted
    output logic power_monitor, // high once pads configured, low when off
    output logic host_access_en // host interfaces open
);
    // measured key pulses from the synchronised pad
    logic on_pulse;
    logic off_pulse;

    // sequencer state
    pwr_seq_pkg::seq_state_t state_q;
    pwr_seq_pkg::seq_state_t state_d;

    // cycles spent in the present state
    logic [31:0] phase_cnt_q;
    logic [31:0] phase_cnt_d;

    // cycles since the accepted power-on pulse
    logic [31:0] boot_cnt_q;
    logic [31:0] boot_cnt_d;

    // state exit conditions
    logic start_req;
    logic stop_req;
    logic pads_done;
    logic boot_done;
    logic final_done;

    // registered pin and status values
    logic ready_q;
    logic ready_d;
    logic monitor_q;
    logic monitor_d;
    logic access_q;
    logic access_d;
    logic gpio8_q;
    logic gpio8_d;
    logic key_out_q;
    logic key_oe_q;

    key_filter u_key_filter (
        .mclk(mclk),
        .nrst(nrst),
        .key_n_in(power_key_n_in),
        .hold_on_cyc(KEY_HOLD_CYC),
        .hold_off_cyc(OFF_KEY_HOLD_CYC),
        .on_pulse(on_pulse),
        .off_pulse(off_pulse)
    );

    // a press only counts as a start while fully off
    assign start_req = on_pulse && (state_q == pwr_seq_pkg::ST_OFF);
    assign stop_req = off_pulse && (state_q == pwr_seq_pkg::ST_ACTIVE);
    assign pads_done = (phase_cnt_q >= PAD_CFG_CYC);
    // counted from release, not press: errs late, never early
    assign boot_done = (boot_cnt_q >= OPER_DELAY_CYC);
    assign final_done = (phase_cnt_q >= FINAL_CYC);

    always_comb begin
        state_d = state_q;
        case (state_q)
            pwr_seq_pkg::ST_OFF: begin
                if (start_req) begin
                    state_d = pwr_seq_pkg::ST_PAD_INIT;
                end
            end
            pwr_seq_pkg::ST_PAD_INIT: begin
                if (pads_done) begin
                    state_d = pwr_seq_pkg::ST_SW_INIT;
                end
            end
            pwr_seq_pkg::ST_SW_INIT: begin
                if (boot_done) begin
                    state_d = pwr_seq_pkg::ST_ACTIVE;
                end
            end
            pwr_seq_pkg::ST_ACTIVE: begin
                if (stop_req) begin
                    state_d = pwr_seq_pkg::ST_FINAL;
                end
            end
            pwr_seq_pkg::ST_FINAL: begin
                if (final_done) begin
                    state_d = pwr_seq_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = pwr_seq_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= pwr_seq_pkg::ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // phase counter restarts on every state change and saturates
    always_comb begin
        if (state_d != state_q) begin
            phase_cnt_d = 32'h0;
        end else if (phase_cnt_q != 32'hffffffff) begin
            phase_cnt_d = phase_cnt_q + 32'h1;
        end else begin
            phase_cnt_d = phase_cnt_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_cnt_q <= 32'h0;
        end else begin
            phase_cnt_q <= phase_cnt_d;
        end
    end

    // boot counter spans both init phases, so pad time is not added on top
    always_comb begin
        if (start_req) begin
            boot_cnt_d = 32'h0;
        end else if (boot_cnt_q != 32'hffffffff) begin
            boot_cnt_d = boot_cnt_q + 32'h1;
        end else begin
            boot_cnt_d = boot_cnt_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_cnt_q <= 32'h0;
        end else begin
            boot_cnt_q <= boot_cnt_d;
        end
    end

    // status decoded from next state so each flop lines up with state_q
    always_comb begin
        ready_d = 1'b0;
        monitor_d = 1'b0;
        access_d = 1'b0;
        case (state_d)
            pwr_seq_pkg::ST_OFF: begin
                monitor_d = 1'b0;
            end
            pwr_seq_pkg::ST_PAD_INIT: begin
                monitor_d = 1'b0;
            end
            pwr_seq_pkg::ST_SW_INIT: begin
                monitor_d = 1'b1;
            end
            pwr_seq_pkg::ST_ACTIVE: begin
                ready_d = 1'b1;
                monitor_d = 1'b1;
                access_d = 1'b1;
            end
            pwr_seq_pkg::ST_FINAL: begin
                monitor_d = 1'b1;
            end
            default: begin
                monitor_d = 1'b0;
            end
        endcase
    end

    // pin eight carries ready unless reconfigured
    always_comb begin
        if (gpio8_alt_sel || !`GPIO8_SW_READY_DEFAULT) begin
            gpio8_d = gpio8_alt_val;
        end else begin
            gpio8_d = ready_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            monitor_q <= 1'b0;
        end else begin
            monitor_q <= monitor_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            access_q <= 1'b0;
        end else begin
            access_q <= access_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gpio8_q <= 1'b0;
        end else begin
            gpio8_q <= gpio8_d;
        end
    end

    // key pad is input only; the host pulls it low, never the module
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            key_out_q <= 1'b0;
            key_oe_q <= 1'b0;
        end else begin
            key_out_q <= 1'b0;
            key_oe_q <= 1'b0;
        end
    end

    assign software_ready = ready_q;
    assign power_monitor = monitor_q;
    assign host_access_en = access_q;
    assign gpio8_out = gpio8_q;
    assign power_key_n_out = key_out_q;
    assign power_key_n_oe = key_oe_q;
endmodule // module_power_on_sequencer

/* dv/pwr_seq_chk.sv */
// assertions on the power-on sequencer ports
`timescale 1ns/10ps
module pwr_seq_chk #(parameter logic [31:0] OPER_DELAY_CYC = 32'h0) (
    input wire logic mclk, nrst, power_key_n_in, power_key_n_oe, gpio8_alt_sel, gpio8_out,
    input wire logic software_ready, power_monitor, host_access_en
);
    logic [31:0] since_q;
    // cycles since a key press taken while off
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst) since_q <= 32'h0;
        else since_q <= (!power_monitor && $fell(power_key_n_in)) ? 32'h0 : since_q + 32'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_up; $rose(software_ready); endsequence
    property p_dly; s_up |-> since_q >= OPER_DELAY_CYC - 32'h1; endproperty
    a_dly: assert property (p_dly) else $error("ready too early");
    property p_pads; software_ready |-> power_monitor; endproperty
    a_pads: assert property (p_pads) else $error("ready before pads");
    property p_acc; host_access_en |-> power_monitor; endproperty
    a_acc: assert property (p_acc) else $error("access open early");
    property p_pin; !$past(gpio8_alt_sel) |-> gpio8_out == software_ready; endproperty
    a_pin: assert property (p_pin) else $error("pin eight wrong");
    property p_off; $fell(power_monitor) |-> !software_ready && !host_access_en; endproperty
    a_off: assert property (p_off) else $error("off while ready");
    property p_oc; !power_key_n_oe; endproperty
    a_oc: assert property (p_oc) else $error("key driven");
endmodule // pwr_seq_chk
bind module_power_on_sequencer pwr_seq_chk #(.OPER_DELAY_CYC(OPER_DELAY_CYC)) u_chk (.mclk, .nrst,
    .power_key_n_in, .power_key_n_oe, .gpio8_alt_sel, .gpio8_out, .software_ready, .power_monitor,
    .host_access_en);

/* dv/pwr_host.sv */
// host key driver, open-collector onto the pulled-up pad
`timescale 1ns/10ps
module pwr_host (
    input wire logic press, // pull the key low
    output logic power_key_n // pad level seen by the module
);
    assign power_key_n = press ? 1'b0 : 1'b1; // released pad sits at pull-up
endmodule // pwr_host

/* dv/test_module_power_on_sequencer.sv */
// bench for the power-on sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module test_module_power_on_sequencer;
logic mclk = 0, nrst = 0, press = 0, sel = 0, val = 0, key_n, gp, rdy, mon, acc;
int error_cnt = 0, samples_checked = 0, i;
pwr_host HOST (.press(press), .power_key_n(key_n));
module_power_on_sequencer #(.KEY_HOLD_CYC(32'h14), .OPER_DELAY_CYC(32'hc8), .PAD_CFG_CYC(32'ha),
    .OFF_KEY_HOLD_CYC(32'h32), .FINAL_CYC(32'h1e)) DUT (.mclk, .nrst, .power_key_n_in(key_n),
    .power_key_n_out(), .power_key_n_oe(), .gpio8_alt_sel(sel), .gpio8_alt_val(val),
    .gpio8_out(gp), .software_ready(rdy), .power_monitor(mon), .host_access_en(acc));
initial forever #5 mclk = ~mclk;
task close_out;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
task pulse(input int n); // hold the key n cycles, then release
    press = 1;
    repeat (n) @(negedge mclk);
    press = 0;
endtask
task wait_st(input logic [1:0] st); // bounded wait for {mon, rdy}
    for (i = 0; i < 1000 && {mon, rdy} !== st; i++) @(negedge mclk);
    `CHK({mon, rdy}, st)
    if (i == 1000) begin error_cnt++; close_out(); end
endtask
task t_short; pulse(10); repeat (400) @(negedge mclk); `CHK(mon, 1'b0) endtask
task t_on;
    pulse(25);
    wait_st(2'h3);
    `CHK(acc, 1'b1)
    `CHK(gp, 1'b1)
    sel = 1;
    @(negedge mclk);
    `CHK(gp, 1'b0)
    sel = 0;
endtask
task t_off; pulse(60); wait_st(2'h0); `CHK(acc, 1'b0) endtask
initial begin
    repeat (8) @(negedge mclk);
    nrst = 1;
    t_short();
    t_on();
    t_off();
    close_out();
end
endmodule // test_module_power_on_sequencer
